// [rtl/slss_pkg.sv]
// Shared constants of the serial link, lockstep and standby control block.
// Assumes one system clock domain and one free-running link shift clock.
package slss_pkg;

    // ****************************************
    // Serial word layout
    // ****************************************
    localparam int unsigned WORD_W         = 18;
    localparam int unsigned LEN_W          = 5;
    localparam logic [4:0]  SHIFT_MULT_ALONE = 5'h0c;
    localparam logic [4:0]  SHIFT_MULT_LOCK  = 5'h12;
    localparam logic [17:0] SYNC_WORD      = 18'h3f000;
    localparam logic        START_BIT      = 1'b1;
    localparam logic        STOP_BIT       = 1'b0;

    // ****************************************
    // Frame timing
    // ****************************************
    localparam logic [8:0]  DEAD_ZONE_ROWS = 9'h005;
    localparam logic [8:0]  VBLANK_RESET   = 9'h004;
    localparam logic        FIXED_ADDR_RESET = 1'b0;

    // ****************************************
    // Power states
    // ****************************************
    typedef enum logic [1:0] {
        ST_RUN,
        ST_DRAIN,
        ST_STANDBY,
        ST_LOCKED
    } slss_state_t;

endpackage

// [rtl/slss_serializer.sv]
// Link-side shifter: loads one word per toggle request and shifts it out MSB first.
// Assumes clk_link is the PLL shift clock and runs freely; request word is held stable.
module slss_serializer #(
    parameter int unsigned WORD_W = 18,
    parameter int unsigned LEN_W  = 5
) (
    // Link clock
    input  wire logic              clk_link,
    // System-domain reset level, synchronised here
    input  wire logic              rst,
    // Word handshake from system domain
    input  wire logic              req_tgl,
    input  wire logic [WORD_W-1:0] word,
    input  wire logic [LEN_W-1:0]  len,
    output logic                   ack_tgl,
    // Serial output
    output logic                   ser_bit
);

    logic              rst_meta_q, rst_link_q;
    logic              req_meta_q, req_sync_q, req_seen_q, req_seen_d;
    logic [WORD_W-1:0] shreg_q, shreg_d;
    logic [LEN_W-1:0]  cnt_q, cnt_d;
    logic              bit_q, bit_d;

    // ****************************************
    // Shift control
    // ****************************************
    always_comb
    begin
        shreg_d    = shreg_q;
        cnt_d      = cnt_q;
        req_seen_d = req_seen_q;
        bit_d      = 1'b0;
        if (cnt_q != '0)
        begin
            bit_d   = shreg_q[WORD_W-1];
            shreg_d = {shreg_q[WORD_W-2:0], 1'b0};
            cnt_d   = cnt_q - 1'b1;
        end
        else if (req_sync_q != req_seen_q)
        begin
            // Word is only reloaded between words so no bit of a word is cut short
            shreg_d    = word;
            cnt_d      = len;
            req_seen_d = req_sync_q;
        end
    end

    always_ff @(posedge clk_link)
    begin
        rst_meta_q <= rst;
        rst_link_q <= rst_meta_q;
        req_meta_q <= req_tgl;
        req_sync_q <= req_meta_q;
        if (rst_link_q)
        begin
            shreg_q    <= '0;
            cnt_q      <= '0;
            req_seen_q <= 1'b0;
            bit_q      <= 1'b0;
        end
        else
        begin
            shreg_q    <= shreg_d;
            cnt_q      <= cnt_d;
            req_seen_q <= req_seen_d;
            bit_q      <= bit_d;
        end
    end

    assign ack_tgl = req_seen_q;
    assign ser_bit = bit_q;

endmodule // slss_serializer

// [rtl/slss_top.sv]
// Serial video output, lockstep check and standby control of the sensor core.
// Assumes pixel data, reserved codes and config bits come from logic on clk_sys;
// standby and address select arrive from pins.

// Function
// - Stand-alone mode shifts twelve serial bits per master clock period.
// - Sync-pattern force bit sends sync words until cleared again.
// - Lockstep mode shifts eighteen bits per master clock, phase aligned.
// - Mismatch flag sets when master and slave reserved codes differ.
// - One address bit fixed inside, other from select input.
// - Standby seen during a frame waits until that readout ends.
// - In standby video and sync outputs float and bus is ignored.
// - Standby in the dead zone locks standby until hardware reset.
module slss_top #(
    parameter int unsigned ROW_LEN     = 16,
    parameter int unsigned ACTIVE_COLS = 10,
    parameter int unsigned ACTIVE_ROWS = 8,
    parameter logic        FIXED_ADDR  = slss_pkg::FIXED_ADDR_RESET
) (
    // Clocks and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        clk_link,
    // Pins
    input  wire logic        standby_pin,
    input  wire logic        addr_select_pin,
    // Configuration bits
    input  wire logic        soft_reset,
    input  wire logic        lvds_driver_disable,
    input  wire logic        lvds_power_down,
    input  wire logic        pll_bypass,
    input  wire logic        lockstep_en,
    input  wire logic        slave_role,
    input  wire logic        force_sync,
    input  wire logic [8:0]  vblank_rows,
    // Pixel source and lockstep codes
    input  wire logic [9:0]  pixel_data,
    input  wire logic        reserved_valid,
    input  wire logic [7:0]  reserved_code_local,
    input  wire logic [7:0]  reserved_code_peer,
    // Parallel video out
    output logic [9:0]       dout,
    output logic             frame_valid,
    output logic             line_valid,
    output logic             video_oe,
    // Serial video out
    output logic             serial_video_out_pos,
    output logic             serial_video_out_neg,
    output logic             serial_video_oe,
    // PLL and bus control
    output logic             pll_enable,
    output logic [4:0]       pll_mult,
    output logic             bus_active,
    output logic [1:0]       bus_addr_bits,
    // Status
    output logic             lockstep_error,
    output logic             in_standby
);

    localparam int unsigned WORD_W = slss_pkg::WORD_W;
    localparam int unsigned LEN_W  = slss_pkg::LEN_W;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic stby_meta_q, stby_q, stby_prev_q;
    logic asel_meta_q, asel_q;

    always_ff @(posedge clk_sys)
    begin
        stby_meta_q <= standby_pin;
        stby_q      <= stby_meta_q;
        asel_meta_q <= addr_select_pin;
        asel_q      <= asel_meta_q;
        stby_prev_q <= rst ? 1'b0 : stby_q;
    end

    wire stby_rise = stby_q & ~stby_prev_q;

    // Equal select levels on both sensors give one shared address
    assign bus_addr_bits = {FIXED_ADDR, asel_q};

    // ****************************************
    // Frame timing and power state
    // ****************************************
    slss_pkg::slss_state_t state_q, state_d;
    logic [15:0] col_q, col_d;
    logic [8:0]  row_q, row_d;
    logic        fv_q, fv_d, lv_q, lv_d;
    logic [9:0]  dout_q, dout_d;

    logic [8:0] vb_rows;
    logic [8:0] dz_start;
    logic       last_col, frame_end, in_vblank, in_dead_zone, running;

    always_comb
    begin
        vb_rows      = (vblank_rows < slss_pkg::VBLANK_RESET) ? slss_pkg::VBLANK_RESET
                                                              : vblank_rows;
        dz_start     = (vb_rows > slss_pkg::DEAD_ZONE_ROWS) ? vb_rows - slss_pkg::DEAD_ZONE_ROWS
                                                            : 9'h000;
        last_col     = (col_q == 16'(ROW_LEN - 1));
        in_vblank    = (row_q >= 9'(ACTIVE_ROWS));
        frame_end    = last_col && (row_q == 9'(ACTIVE_ROWS - 1));
        // Window of blank rows just before the next frame starts
        in_dead_zone = in_vblank && ((row_q - 9'(ACTIVE_ROWS)) >= dz_start);
        running      = (state_q == slss_pkg::ST_RUN) || (state_q == slss_pkg::ST_DRAIN);
    end

    always_comb
    begin
        state_d = state_q;
        col_d   = col_q;
        row_d   = row_q;
        case (state_q)
            slss_pkg::ST_RUN:
            begin
                if (stby_rise)
                begin
                    if (!in_vblank)
                        state_d = slss_pkg::ST_DRAIN;
                    else if (in_dead_zone)
                        state_d = slss_pkg::ST_LOCKED;
                    else
                        state_d = slss_pkg::ST_STANDBY;
                end
            end
            slss_pkg::ST_DRAIN:
            begin
                // Current readout is completed before the outputs are released
                if (frame_end)
                    state_d = slss_pkg::ST_STANDBY;
            end
            slss_pkg::ST_STANDBY:
            begin
                if (!stby_q)
                    state_d = slss_pkg::ST_RUN;
            end
            slss_pkg::ST_LOCKED:
            begin
                // Only the hardware reset leaves this state; soft reset cannot
                state_d = slss_pkg::ST_LOCKED;
            end
            default:
            begin
                state_d = slss_pkg::ST_RUN;
            end
        endcase

        if (running)
        begin
            if (last_col)
            begin
                col_d = '0;
                row_d = (row_q == 9'(ACTIVE_ROWS) + vb_rows - 9'h001) ? 9'h000
                                                                     : row_q + 9'h001;
            end
            else
            begin
                col_d = col_q + 16'h0001;
            end
        end
        else if (state_q == slss_pkg::ST_STANDBY)
        begin
            // Wake-up starts at a frame boundary
            col_d = '0;
            row_d = '0;
        end
        if (soft_reset)
        begin
            col_d = '0;
            row_d = '0;
        end

        fv_d   = running && !in_vblank && !soft_reset;
        lv_d   = fv_d && (col_q < 16'(ACTIVE_COLS));
        dout_d = lv_d ? pixel_data : 10'h000;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_q <= slss_pkg::ST_RUN;
            col_q   <= '0;
            row_q   <= '0;
            fv_q    <= 1'b0;
            lv_q    <= 1'b0;
            dout_q  <= '0;
        end
        else
        begin
            state_q <= state_d;
            col_q   <= col_d;
            row_q   <= row_d;
            fv_q    <= fv_d;
            lv_q    <= lv_d;
            dout_q  <= dout_d;
        end
    end

    assign in_standby  = (state_q == slss_pkg::ST_STANDBY) || (state_q == slss_pkg::ST_LOCKED);
    assign dout        = dout_q;
    assign frame_valid = fv_q;
    assign line_valid  = lv_q;
    assign video_oe    = ~in_standby;
    assign bus_active  = ~in_standby;

    // ****************************************
    // Lockstep mismatch flag
    // ****************************************
    logic err_q, err_d;

    always_comb
    begin
        err_d = err_q;
        if (soft_reset)
            err_d = 1'b0;
        // A mismatch in the clearing cycle still sets the flag
        if (lockstep_en && reserved_valid && (reserved_code_local != reserved_code_peer))
            err_d = 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        err_q <= rst ? 1'b0 : err_d;
    end

    assign lockstep_error = err_q;

    // ****************************************
    // PLL control and serial word handoff
    // ****************************************
    // Link clock is this PLL's output: x12 stand-alone, x18 phase-aligned in lockstep
    assign pll_mult   = lockstep_en ? slss_pkg::SHIFT_MULT_LOCK : slss_pkg::SHIFT_MULT_ALONE;
    assign pll_enable = ~pll_bypass & ~lvds_power_down;

    logic              req_q, req_d;
    logic [WORD_W-1:0] word_q, word_d;
    logic [LEN_W-1:0]  len_q, len_d;
    logic              ack_tgl, ack_meta_q, ack_q;
    logic              ser_bit;

    always_comb
    begin
        req_d  = req_q;
        word_d = word_q;
        len_d  = len_q;
        // Words between handoffs are dropped: no buffer, the link runs slower here
        if (ack_q == req_q)
        begin
            req_d = ~req_q;
            len_d = lockstep_en ? slss_pkg::SHIFT_MULT_LOCK : slss_pkg::SHIFT_MULT_ALONE;
            if (force_sync)
                word_d = slss_pkg::SYNC_WORD;
            else if (lockstep_en)
                word_d = {slss_pkg::START_BIT, dout_q[9:2], fv_q, lv_q, slave_role, 5'h00,
                          slss_pkg::STOP_BIT};
            else
                word_d = {slss_pkg::START_BIT, dout_q, slss_pkg::STOP_BIT, 6'h00};
        end
    end

    always_ff @(posedge clk_sys)
    begin
        ack_meta_q <= ack_tgl;
        ack_q      <= ack_meta_q;
        if (rst)
        begin
            req_q  <= 1'b0;
            word_q <= '0;
            len_q  <= '0;
        end
        else
        begin
            req_q  <= req_d;
            word_q <= word_d;
            len_q  <= len_d;
        end
    end

    slss_serializer #(
        .WORD_W (WORD_W),
        .LEN_W  (LEN_W)
    ) u_ser (
        .clk_link (clk_link),
        .rst      (rst),
        .req_tgl  (req_q),
        .word     (word_q),
        .len      (len_q),
        .ack_tgl  (ack_tgl),
        .ser_bit  (ser_bit)
    );

    assign serial_video_oe      = ~lvds_driver_disable & ~lvds_power_down & ~in_standby;
    assign serial_video_out_pos = ser_bit;
    assign serial_video_out_neg = ~ser_bit;

endmodule // slss_top

// [tb/slss_checker.sv]
// Port-level assertions for the serial link, lockstep and standby block.
// Assumes the top module's port names; attached by the bind at the foot.
module slss_checker #(
    parameter logic FIXED_ADDR = 1'b0
) (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       rst,
    // Inputs watched
    input wire logic       addr_select_pin,
    input wire logic       lockstep_en,
    input wire logic       soft_reset,
    input wire logic       reserved_valid,
    input wire logic [7:0] reserved_code_local,
    input wire logic [7:0] reserved_code_peer,
    // Outputs watched
    input wire logic [4:0] pll_mult,
    input wire logic       video_oe,
    input wire logic       bus_active,
    input wire logic [1:0] bus_addr_bits,
    input wire logic       frame_valid,
    input wire logic       line_valid,
    input wire logic       lockstep_error,
    input wire logic       in_standby
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_mismatch;
        reserved_valid && lockstep_en && (reserved_code_local != reserved_code_peer);
    endsequence
    sequence s_held_standby;
        in_standby [*2];
    endsequence
    a_mult_alone: assert property (!lockstep_en |-> pll_mult == 5'h0c)
        else $error("shift multiplier wrong in stand-alone mode");
    a_mult_lock: assert property (lockstep_en |-> pll_mult == 5'h12)
        else $error("shift multiplier wrong in lockstep mode");
    a_standby_quiet: assert property (in_standby |-> !video_oe && !bus_active)
        else $error("outputs or bus live in standby");
    a_standby_no_frame: assert property (s_held_standby |-> !frame_valid)
        else $error("frame valid while in standby");
    a_drain_end: assert property ($rose(in_standby) |-> !line_valid)
        else $error("standby entered inside a line");
    a_error_set: assert property (s_mismatch |=> lockstep_error)
        else $error("mismatch flag not set");
    a_error_sticky: assert property (lockstep_error && !soft_reset |=> lockstep_error)
        else $error("mismatch flag dropped on its own");
    a_error_cause: assert property ($rose(lockstep_error) |-> $past(reserved_valid) && $past(lockstep_en))
        else $error("mismatch flag set without a code check");
    a_addr_fixed: assert property (bus_addr_bits[1] == FIXED_ADDR)
        else $error("fixed address bit wrong");
    a_addr_sync: assert property (!$past(rst) && !$past(rst, 2) |-> bus_addr_bits[0] == $past(addr_select_pin, 2))
        else $error("address bit does not follow select pin");
endmodule // slss_checker

bind slss_top slss_checker #(.FIXED_ADDR(FIXED_ADDR)) u_chk (.*);

// [tb/slss_host_model.sv]
// Host-side driver of the standby and address-select pins.
// Assumes the bench sets the wanted levels; pins move just after clk_sys edges.
module slss_host_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Wanted levels from the bench
    input wire logic want_standby,
    input wire logic want_sel,
    // Pins
    output logic     standby_pin,
    output logic     addr_select_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    int unsigned edges_q = 0;
    // Bus side stays quiet until enough edges have passed after reset;
    // select pin rests low meanwhile and standby pin during reset, so only the level sampled at the first edge, before either pin is driven, is unknown
    always @(posedge clk_sys)
    begin
        edges_q <= rst ? 0 : (edges_q < 10 ? edges_q + 1 : edges_q);
        standby_pin <= #2 rst ? 1'b0 : want_standby;
        addr_select_pin <= #2 (edges_q >= 10) ? want_sel : 1'b0;
    end
endmodule // slss_host_model

// [tb/tb_top.sv]
// Self-checking bench for the serial link, lockstep and standby block.
// Assumes slss_pkg, the design, checker and host model are compiled first.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // ****************
    // Signals
    // ****************
    logic        clk_sys = 0, rst = 1, clk_link = 0, want_standby = 0, want_sel = 0;
    logic        standby_pin, addr_select_pin, soft_reset = 0, slave_role = 0;
    logic        lvds_driver_disable = 0, lvds_power_down = 0, pll_bypass = 0;
    logic        lockstep_en = 0, force_sync = 0, reserved_valid = 0;
    logic [8:0]  vblank_rows = 9'h004;
    logic [9:0]  pixel_data = 10'h2a5, dout;
    logic [7:0]  reserved_code_local = 8'h00, reserved_code_peer = 8'h00;
    logic        frame_valid, line_valid, video_oe, serial_video_oe, pll_enable;
    logic        serial_video_out_pos, serial_video_out_neg, bus_active;
    logic        lockstep_error, in_standby;
    logic [4:0]  pll_mult;
    logic [1:0]  bus_addr_bits;
    logic [17:0] win_q = 18'h00000;
    int          fail_count = 0, n_tests = 0;

    always #12.5 clk_sys = ~clk_sys;
    initial
    begin
        #7.3;
        forever #80 clk_link = ~clk_link;
    end
    always @(posedge clk_link) win_q <= {win_q[16:0], serial_video_out_pos};

    slss_top        dut  (.*);
    slss_host_model host (.*);

    // ****************
    // Tasks
    // ****************
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            $display("ERROR %0t: %s", $time, what);
            fail_count++;
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Which: 0 frame valid, 1 line valid, 2 standby
    task automatic wait_on(input int which, input logic lvl, input int bound);
        logic v;
        for (int i = 0; i < bound; i++)
        begin
            v = which == 0 ? frame_valid : which == 1 ? line_valid : in_standby;
            if (v === lvl)
                return;
            step(1);
        end
        $display("ERROR %0t: wait %0d timed out", $time, which);
        fail_count++;
        close_out();
    endtask
    task automatic do_reset();
        rst = 1;
        step(30);
        rst = 0;
    endtask
    task automatic t_link();
        chk(pll_mult, 5'h0c, "multiplier stand-alone");
        chk({pll_enable, serial_video_oe}, 2'h3, "link on");
        lvds_power_down = 1;
        step(1);
        chk({pll_enable, serial_video_oe}, 2'h0, "link powered down");
        lvds_power_down = 0;
        pll_bypass = 1;
        lvds_driver_disable = 1;
        step(1);
        chk({pll_enable, serial_video_oe}, 2'h0, "bypass, driver off");
        pll_bypass = 0;
        lvds_driver_disable = 0;
        lockstep_en = 1;
        step(1);
        chk(pll_mult, 5'h12, "multiplier lockstep");
        lockstep_en = 0;
        $display("t_link done");
    endtask
    // Lockstep bring-up of the master, then the slave, one step per write; power-down with bypass and lockstep enable with blank rows share a step each
    task automatic t_lock();
        lvds_power_down = 0;
        pll_bypass = 1;
        step(1);
        lockstep_en = 1;
        vblank_rows = 9'h004;
        step(1);
        lvds_driver_disable = 0;
        step(1);
        chk({pll_mult, pll_enable, serial_video_oe}, {5'h12, 2'h1}, "master bypassed");
        pll_bypass = 0;
        step(1);
        slave_role = 1;
        step(1);
        chk(pll_enable, 1'h1, "slave pll running");
        soft_reset = 1;
        step(1);
        chk({frame_valid, line_valid}, 2'h0, "soft reset stops frame");
        soft_reset = 0;
        lockstep_en = 0;
        slave_role = 0;
        $display("t_lock done");
    endtask
    task automatic t_addr();
        want_sel = 1;
        step(4);
        chk(bus_addr_bits, 2'h1, "select high");
        want_sel = 0;
        step(4);
        chk(bus_addr_bits, 2'h0, "select low");
        $display("t_addr done");
    endtask
    task automatic t_mismatch();
        lockstep_en = 1;
        reserved_code_local = 8'h5a;
        reserved_code_peer = 8'h5a;
        reserved_valid = 1;
        step(1);
        chk(lockstep_error, 1'h0, "equal codes");
        reserved_code_peer = 8'ha5;
        step(1);
        reserved_valid = 0;
        chk(lockstep_error, 1'h1, "codes differ");
        step(3);
        chk(lockstep_error, 1'h1, "flag holds");
        // Make codes equal, then pulse soft reset until the flag clears, at most four rounds
        reserved_code_peer = reserved_code_local;
        for (int i = 0; i < 4 && lockstep_error; i++)
        begin
            soft_reset = 1;
            step(1);
            soft_reset = 0;
            step(1);
        end
        chk(lockstep_error, 1'h0, "soft reset clears");
        reserved_code_peer = 8'ha5;
        reserved_valid = 1;
        soft_reset = 1;
        step(1);
        chk(lockstep_error, 1'h1, "set wins over clear");
        reserved_valid = 0;
        step(1);
        soft_reset = 0;
        lockstep_en = 0;
        reserved_valid = 1;
        step(1);
        reserved_valid = 0;
        chk(lockstep_error, 1'h0, "no check outside lockstep");
        $display("t_mismatch done");
    endtask
    task automatic t_sync();
        force_sync = 1;
        // Stand-alone words carry twelve bits, then one idle low bit
        repeat (100)
            if (win_q[12:0] !== {slss_pkg::SYNC_WORD[17:6], 1'b0})
            begin
                @(posedge clk_link);
                #1;
            end
        chk(win_q[12:0], {slss_pkg::SYNC_WORD[17:6], 1'b0}, "sync word stand-alone");
        chk(serial_video_out_pos ^ serial_video_out_neg, 1'h1, "pair not inverse");
        step(1);
        lockstep_en = 1;
        repeat (100)
            if (win_q !== slss_pkg::SYNC_WORD)
            begin
                @(posedge clk_link);
                #1;
            end
        chk(win_q, slss_pkg::SYNC_WORD, "sync word on link");
        step(1);
        force_sync = 0;
        lockstep_en = 0;
        $display("t_sync done");
    endtask
    task automatic t_drain();
        wait_on(0, 1'h1, 300);
        wait_on(1, 1'h1, 20);
        chk(dout, 10'h2a5, "pixel on parallel bus");
        want_standby = 1;
        step(6);
        chk(in_standby, 1'h0, "frame still read out");
        wait_on(0, 1'h0, 300);
        step(2);
        chk({in_standby, video_oe, bus_active}, 3'h4, "standby outputs off");
        want_standby = 0;
        wait_on(2, 1'h0, 10);
        wait_on(0, 1'h1, 300);
        $display("t_drain done");
    endtask
    task automatic t_safe();
        vblank_rows = 9'h00a;
        wait_on(0, 1'h1, 400);
        wait_on(0, 1'h0, 400);
        want_standby = 1;
        step(6);
        chk(in_standby, 1'h1, "standby at frame end");
        step(15 * 16);
        want_standby = 0;
        wait_on(2, 1'h0, 10);
        wait_on(0, 1'h1, 300);
        $display("t_safe done");
    endtask
    task automatic t_dead();
        wait_on(0, 1'h1, 400);
        wait_on(0, 1'h0, 400);
        // Lands in the last five blank rows
        step(7 * 16);
        want_standby = 1;
        step(8);
        want_standby = 0;
        step(300);
        chk({in_standby, frame_valid}, 2'h2, "held in standby");
        do_reset();
        wait_on(0, 1'h1, 300);
        chk(in_standby, 1'h0, "reset leaves lock");
        $display("t_dead done");
    endtask

    initial
    begin
        do_reset();
        step(10);
        t_link();
        t_lock();
        t_addr();
        t_mismatch();
        t_sync();
        t_drain();
        t_safe();
        t_dead();
        close_out();
    end
endmodule // tb_top
